// [common/srs_consts.svh]
// Constants for the status register set: widths, masks and reset values
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

// Ordinary set width and its top-bit mask
`define SRS_ORD_W 16
`define SRS_ORD_MASK 16'h7fff

// Standard event set width
`define SRS_STD_W 8
`define SRS_STD_MASK 8'hff

// Access data width is the widest set
`define SRS_DATA_W 16

// Reset values of the software registers
`define SRS_ORD_PTR_RST 16'h7fff
`define SRS_ORD_NTR_RST 16'h0000
`define SRS_ORD_ENA_RST 16'h0000
`define SRS_STD_PTR_RST 8'hff
`define SRS_STD_NTR_RST 8'h00
`define SRS_STD_ENA_RST 8'h00

// Zero words
`define SRS_ZERO_DATA 16'h0000
`define SRS_ZERO_STD 8'h00

`endif

// [common/srs_pkg.sv]
// Types shared by the status register set files
package srs_pkg;

    // Which register an access names
    typedef enum logic [2:0] {
        SRS_REG_COND,
        SRS_REG_PTR,
        SRS_REG_NTR,
        SRS_REG_EVENT,
        SRS_REG_ENABLE
    } srs_reg_t;

    // Which register set an access names
    typedef enum logic {
        SRS_SET_ORD,
        SRS_SET_STD
    } srs_set_t;

endpackage

// [hdl/srs_event_latch.sv]
// Transition filtering and sticky event latch for one register set
`timescale 1ns/1ns
`default_nettype none

module srs_event_latch #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] condIn,
    input wire logic [WIDTH-1:0] posFilter,
    input wire logic [WIDTH-1:0] negFilter,
    input wire logic clearEvents,
    output logic [WIDTH-1:0] events
);

    logic [WIDTH-1:0] condPrev_q;
    logic [WIDTH-1:0] condPrev_d;
    logic [WIDTH-1:0] event_q;
    logic [WIDTH-1:0] event_d;
    logic [WIDTH-1:0] eventSet;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            // Edge seen against last clock's copy, filtered the same cycle
            assign eventSet[i] = (condIn[i] & ~condPrev_q[i] & posFilter[i])   // see R6, R8, R16
                               | (~condIn[i] & condPrev_q[i] & negFilter[i]);  // see R7, R8, R16
        end
    endgenerate

    always_comb begin
        condPrev_d = condIn;
        // Set wins over clear so an edge in the clearing cycle survives
        if (clearEvents) begin
            event_d = eventSet;  // see R11, R12
        end else begin
            event_d = event_q | eventSet;  // see R10, R13
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            condPrev_q <= '0;
            event_q <= '0;
        end else begin
            condPrev_q <= condPrev_d;
            event_q <= event_d;
        end
    end

    assign events = event_q;

endmodule

`default_nettype wire

// [hdl/srs_status_set.sv]
// Status register set: one ordinary 16-bit set and the 8-bit standard event set
//
// Summary of operation
// R1 - Ordinary set is sixteen bits; bit 15 always reads zero.
// R2 - Standard event set is eight bits wide.
// R3 - Condition bits are never latched; they follow live conditions.
// R4 - Condition bit is one while condition true, zero once false.
// R5 - Condition register readable; writes to it are ignored.
// R6 - Rising condition edge sets event bit only if positive filter set.
// R7 - Falling condition edge sets event bit only if negative filter set.
// R8 - Both filters set: either edge direction sets the event bit.
// R9 - Positive and negative filter registers are readable and writable.
// R10 - Event bit stays set until its event register is cleared.
// R11 - Reading an event register returns it and clears it.
// R12 - Clear-status command clears every event register at once.
// R13 - Event registers cannot be written by software.
// R14 - Summary is OR of enabled event bits.
// R15 - Enable registers are readable and writable.
// R16 - Edges found against previous-clock copy; events set that same cycle.
`timescale 1ns/1ns
`default_nettype none

`include "srs_consts.svh"

module srs_status_set
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`SRS_ORD_W-1:0] ordCond,
    input wire logic [`SRS_STD_W-1:0] stdCond,
    input wire logic clearStatus,
    input wire logic accValid,
    input wire logic accWrite,
    input wire srs_set_t accSet,
    input wire srs_reg_t accReg,
    input wire logic [`SRS_DATA_W-1:0] accWData,
    output logic [`SRS_DATA_W-1:0] accRData,
    output logic accRValid,
    output logic ordSummary,
    output logic stdSummary
);

    // Decodes one access; shared by every register strobe
    function automatic logic hit(
        input logic valid,
        input logic write,
        input logic wantWrite,
        input srs_set_t set,
        input srs_set_t wantSet,
        input srs_reg_t regSel,
        input srs_reg_t wantReg
    );
        hit = valid && (write == wantWrite) && (set == wantSet) && (regSel == wantReg);
    endfunction

    logic [`SRS_ORD_W-1:0] ordCondLive;
    logic [`SRS_STD_W-1:0] stdCondLive;
    logic [`SRS_ORD_W-1:0] ordEvents;
    logic [`SRS_STD_W-1:0] stdEvents;
    logic ordEventRead;
    logic stdEventRead;

    // Software registers
    logic [`SRS_ORD_W-1:0] ordPtr_q;
    logic [`SRS_ORD_W-1:0] ordPtr_d;
    logic [`SRS_ORD_W-1:0] ordNtr_q;
    logic [`SRS_ORD_W-1:0] ordNtr_d;
    logic [`SRS_ORD_W-1:0] ordEna_q;
    logic [`SRS_ORD_W-1:0] ordEna_d;
    logic [`SRS_STD_W-1:0] stdPtr_q;
    logic [`SRS_STD_W-1:0] stdPtr_d;
    logic [`SRS_STD_W-1:0] stdNtr_q;
    logic [`SRS_STD_W-1:0] stdNtr_d;
    logic [`SRS_STD_W-1:0] stdEna_q;
    logic [`SRS_STD_W-1:0] stdEna_d;

    // Read port and summaries
    logic [`SRS_DATA_W-1:0] rData_q;
    logic [`SRS_DATA_W-1:0] rData_d;
    logic rValid_q;
    logic rValid_d;
    logic ordSum_q;
    logic ordSum_d;
    logic stdSum_q;
    logic stdSum_d;

    // Bit 15 of the wide set is never a live condition
    assign ordCondLive = ordCond & `SRS_ORD_MASK;  // see R1, R3, R4
    assign stdCondLive = stdCond;  // see R2, R3, R4

    // Read-to-clear strobes; reads of other registers leave events alone
    assign ordEventRead = hit(accValid, accWrite, 1'b0, accSet, SRS_SET_ORD,
                              accReg, SRS_REG_EVENT);
    assign stdEventRead = hit(accValid, accWrite, 1'b0, accSet, SRS_SET_STD,
                              accReg, SRS_REG_EVENT);

    srs_event_latch #(
        .WIDTH(`SRS_ORD_W)
    ) uOrdLatch (
        .clk(clk),
        .reset(reset),
        .condIn(ordCondLive),
        .posFilter(ordPtr_q),
        .negFilter(ordNtr_q),
        .clearEvents(ordEventRead | clearStatus),  // see R11, R12
        .events(ordEvents)
    );

    srs_event_latch #(
        .WIDTH(`SRS_STD_W)
    ) uStdLatch (
        .clk(clk),
        .reset(reset),
        .condIn(stdCondLive),
        .posFilter(stdPtr_q),
        .negFilter(stdNtr_q),
        .clearEvents(stdEventRead | clearStatus),  // see R11, R12
        .events(stdEvents)
    );

    // Software-writable registers; condition and event writes have no target
    always_comb begin
        ordPtr_d = ordPtr_q;
        ordNtr_d = ordNtr_q;
        ordEna_d = ordEna_q;
        stdPtr_d = stdPtr_q;
        stdNtr_d = stdNtr_q;
        stdEna_d = stdEna_q;
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_ORD, accReg, SRS_REG_PTR)) begin
            ordPtr_d = accWData & `SRS_ORD_MASK;  // see R9, R1
        end
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_ORD, accReg, SRS_REG_NTR)) begin
            ordNtr_d = accWData & `SRS_ORD_MASK;  // see R9, R1
        end
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_ORD, accReg, SRS_REG_ENABLE)) begin
            ordEna_d = accWData & `SRS_ORD_MASK;  // see R15, R1
        end
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_STD, accReg, SRS_REG_PTR)) begin
            stdPtr_d = accWData[`SRS_STD_W-1:0];  // see R9
        end
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_STD, accReg, SRS_REG_NTR)) begin
            stdNtr_d = accWData[`SRS_STD_W-1:0];  // see R9
        end
        if (hit(accValid, accWrite, 1'b1, accSet, SRS_SET_STD, accReg, SRS_REG_ENABLE)) begin
            stdEna_d = accWData[`SRS_STD_W-1:0];  // see R15
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ordPtr_q <= `SRS_ORD_PTR_RST;
            ordNtr_q <= `SRS_ORD_NTR_RST;
            ordEna_q <= `SRS_ORD_ENA_RST;
            stdPtr_q <= `SRS_STD_PTR_RST;
            stdNtr_q <= `SRS_STD_NTR_RST;
            stdEna_q <= `SRS_STD_ENA_RST;
        end else begin
            ordPtr_q <= ordPtr_d;
            ordNtr_q <= ordNtr_d;
            ordEna_q <= ordEna_d;
            stdPtr_q <= stdPtr_d;
            stdNtr_q <= stdNtr_d;
            stdEna_q <= stdEna_d;
        end
    end

    // Read mux; data held until the next read, narrow set zero-extended
    always_comb begin
        rData_d = rData_q;
        rValid_d = accValid && !accWrite;
        if (accValid && !accWrite) begin
            rData_d = `SRS_ZERO_DATA;
            if (accSet == SRS_SET_ORD) begin
                case (accReg)
                    SRS_REG_COND: begin
                        rData_d = ordCondLive;  // see R5
                    end
                    SRS_REG_PTR: begin
                        rData_d = ordPtr_q;  // see R9
                    end
                    SRS_REG_NTR: begin
                        rData_d = ordNtr_q;  // see R9
                    end
                    SRS_REG_EVENT: begin
                        rData_d = ordEvents;  // see R11
                    end
                    SRS_REG_ENABLE: begin
                        rData_d = ordEna_q;  // see R15
                    end
                    default: begin
                        rData_d = `SRS_ZERO_DATA;
                    end
                endcase
                rData_d = rData_d & `SRS_ORD_MASK;  // see R1
            end else begin
                case (accReg)
                    SRS_REG_COND: begin
                        rData_d = {`SRS_ZERO_STD, stdCondLive};  // see R5
                    end
                    SRS_REG_PTR: begin
                        rData_d = {`SRS_ZERO_STD, stdPtr_q};
                    end
                    SRS_REG_NTR: begin
                        rData_d = {`SRS_ZERO_STD, stdNtr_q};
                    end
                    SRS_REG_EVENT: begin
                        rData_d = {`SRS_ZERO_STD, stdEvents};  // see R11
                    end
                    SRS_REG_ENABLE: begin
                        rData_d = {`SRS_ZERO_STD, stdEna_q};
                    end
                    default: begin
                        rData_d = `SRS_ZERO_DATA;
                    end
                endcase
            end
        end
    end

    // Summaries registered from registered events: one clock behind, glitch free
    always_comb begin
        ordSum_d = |(ordEvents & ordEna_q);  // see R14
        stdSum_d = |(stdEvents & stdEna_q);  // see R14
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rData_q <= `SRS_ZERO_DATA;
            rValid_q <= 1'b0;
            ordSum_q <= 1'b0;
            stdSum_q <= 1'b0;
        end else begin
            rData_q <= rData_d;
            rValid_q <= rValid_d;
            ordSum_q <= ordSum_d;
            stdSum_q <= stdSum_d;
        end
    end

    assign accRData = rData_q;
    assign accRValid = rValid_q;
    assign ordSummary = ordSum_q;
    assign stdSummary = stdSum_q;

endmodule

`default_nettype wire

// [bench/srs_ctrl_model.sv]
// Controller model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module srs_ctrl_model
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic [15:0] accRData,
    input wire logic accRValid,
    output logic accValid,
    output logic accWrite,
    output srs_set_t accSet,
    output srs_reg_t accReg,
    output logic [15:0] accWData
);
    initial begin
        accValid = 1'b0;
        accWrite = 1'b0;
        accSet = SRS_SET_ORD;
        accReg = SRS_REG_COND;
        accWData = 16'h0000;
    end
    // One access; answer sampled just after the edge that follows
    task automatic xfer(input logic wr, input srs_set_t s, input srs_reg_t r,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
        @(posedge clk);
        accValid <= 1'b1;
        accWrite <= wr;
        accSet <= s;
        accReg <= r;
        accWData <= wd;
        @(posedge clk);
        accValid <= 1'b0;
        accWData <= ~wd; // Idle data never repeats the last word
        #1;
        ok = (accRValid === !wr);
        rd = accRData;
    endtask
endmodule
`default_nettype wire

// [bench/srs_status_set_assertions.sv]
// Port-level checks on the status register set
`timescale 1ns/1ns
`default_nettype none
`include "srs_consts.svh"
module srs_status_set_assertions
    import srs_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`SRS_ORD_W-1:0] ordCond,
    input wire logic [`SRS_STD_W-1:0] stdCond,
    input wire logic clearStatus,
    input wire logic accValid,
    input wire logic accWrite,
    input wire srs_set_t accSet,
    input wire srs_reg_t accReg,
    input wire logic [`SRS_DATA_W-1:0] accWData,
    input wire logic [`SRS_DATA_W-1:0] accRData,
    input wire logic accRValid,
    input wire logic ordSummary,
    input wire logic stdSummary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic rdReq;
    logic ordEvRd;
    assign rdReq = accValid && !accWrite;
    assign ordEvRd = rdReq && accSet == SRS_SET_ORD && accReg == SRS_REG_EVENT;
    a_read_answered: assert property (rdReq |=> accRValid)
        else $error("read got no answer");
    a_no_stray_answer: assert property (!rdReq |=> !accRValid)
        else $error("answer without read");
    a_rdata_holds: assert property (!accRValid |-> $stable(accRData))
        else $error("read data moved without read");
    a_top_bit_zero: assert property (rdReq && accSet == SRS_SET_ORD |=> !accRData[15])
        else $error("top bit read as one");
    a_std_narrow: assert property (rdReq && accSet == SRS_SET_STD |=> accRData[15:8] == 8'h00)
        else $error("standard read wider than a byte");
    a_cond_live: assert property (rdReq && accSet == SRS_SET_ORD && accReg == SRS_REG_COND
        |=> accRData == ($past(ordCond) & `SRS_ORD_MASK))
        else $error("condition read not live");
    // Controller reads come every other cycle, so one quiet cycle sits between
    a_read_clears: assert property ((ordEvRd && $stable(ordCond)) ##1 $stable(ordCond) ##1
        (ordEvRd && $stable(ordCond)) |=> accRData == 16'h0000)
        else $error("event read did not clear");
    a_ord_clr_summary: assert property (clearStatus && $stable(ordCond) |=> ##1 !ordSummary)
        else $error("ordinary summary after clear");
    a_std_clr_summary: assert property (clearStatus && $stable(stdCond) |=> ##1 !stdSummary)
        else $error("standard summary after clear");
    c_event_seen: cover property (ordEvRd ##1 accRData != 16'h0000);
    c_clear: cover property (clearStatus);
    c_summary: cover property ($rose(ordSummary) && $rose(stdSummary));
endmodule
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the status register set
`timescale 1ns/1ns
`default_nettype none
module tb;
    import srs_pkg::*;
    logic clk, reset, clearStatus, accValid, accWrite, accRValid, ordSummary, stdSummary;
    logic [15:0] ordCond, accWData, accRData;
    logic [7:0] stdCond;
    srs_set_t accSet;
    srs_reg_t accReg;
    int mismatches = 0;
    int checks_done = 0;
    srs_status_set srs_status_set_inst(.clk(clk), .reset(reset), .ordCond(ordCond),
        .stdCond(stdCond), .clearStatus(clearStatus), .accValid(accValid),
        .accWrite(accWrite), .accSet(accSet), .accReg(accReg), .accWData(accWData),
        .accRData(accRData), .accRValid(accRValid), .ordSummary(ordSummary),
        .stdSummary(stdSummary));
    srs_ctrl_model srs_ctrl_model_inst(.clk(clk), .accRData(accRData), .accRValid(accRValid),
        .accValid(accValid), .accWrite(accWrite), .accSet(accSet), .accReg(accReg),
        .accWData(accWData));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input srs_set_t s, input srs_reg_t r, input logic [15:0] d);
        logic [15:0] q;
        logic ok;
        srs_ctrl_model_inst.xfer(1'b1, s, r, d, q, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask
    task automatic rd(input srs_set_t s, input srs_reg_t r, input logic [15:0] exp);
        logic [15:0] q;
        logic ok;
        srs_ctrl_model_inst.xfer(1'b0, s, r, 16'h0000, q, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(q, exp);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic test_reset_values();
        rd(SRS_SET_ORD, SRS_REG_PTR, 16'h7fff);
        rd(SRS_SET_ORD, SRS_REG_NTR, 16'h0000);
        rd(SRS_SET_ORD, SRS_REG_ENABLE, 16'h0000);
        rd(SRS_SET_STD, SRS_REG_PTR, 16'h00ff);
        $display("test reset values done");
    endtask
    task automatic test_access();
        wr(SRS_SET_ORD, SRS_REG_PTR, 16'hffff);
        rd(SRS_SET_ORD, SRS_REG_PTR, 16'h7fff);
        wr(SRS_SET_ORD, SRS_REG_NTR, 16'h1234);
        rd(SRS_SET_ORD, SRS_REG_NTR, 16'h1234);
        wr(SRS_SET_STD, SRS_REG_ENABLE, 16'hffa5);
        rd(SRS_SET_STD, SRS_REG_ENABLE, 16'h00a5);
        wr(SRS_SET_ORD, SRS_REG_COND, 16'h00ff);
        rd(SRS_SET_ORD, SRS_REG_COND, 16'h0000);
        wr(SRS_SET_ORD, SRS_REG_EVENT, 16'h00ff);
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0000);
        $display("test access done");
    endtask
    task automatic test_transitions();
        wr(SRS_SET_ORD, SRS_REG_PTR, 16'h0005);
        wr(SRS_SET_ORD, SRS_REG_NTR, 16'h0006);
        @(posedge clk) ordCond <= 16'h8007;
        rd(SRS_SET_ORD, SRS_REG_COND, 16'h0007);
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0005);
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0000);
        @(posedge clk) ordCond <= 16'h0000;
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0006);
        @(posedge clk) ordCond <= 16'h0001;
        @(posedge clk) ordCond <= 16'h0000;
        rd(SRS_SET_ORD, SRS_REG_COND, 16'h0000);
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0001);
        $display("test transitions done");
    endtask
    task automatic test_summary_clear();
        wr(SRS_SET_ORD, SRS_REG_ENABLE, 16'h0001);
        wr(SRS_SET_STD, SRS_REG_ENABLE, 16'h0001);
        @(posedge clk) ordCond <= 16'h0001;
        stdCond <= 8'h01;
        repeat (3) @(posedge clk);
        #1 chk({14'h0000, ordSummary, stdSummary}, 16'h0003);
        wr(SRS_SET_ORD, SRS_REG_ENABLE, 16'h0000);
        // Summary is registered, so it lags the enable write by one clock
        @(posedge clk) #1 chk({15'h0000, ordSummary}, 16'h0000);
        @(posedge clk) clearStatus <= 1'b1;
        @(posedge clk) clearStatus <= 1'b0;
        @(posedge clk) #1 chk({15'h0000, stdSummary}, 16'h0000);
        rd(SRS_SET_ORD, SRS_REG_EVENT, 16'h0000);
        rd(SRS_SET_STD, SRS_REG_EVENT, 16'h0000);
        $display("test summary and clear done");
    endtask
    initial begin
        reset = 1'b1;
        ordCond = 16'h0000;
        stdCond = 8'h00;
        clearStatus = 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        test_reset_values();
        test_access();
        test_transitions();
        test_summary_clear();
        report_and_stop();
    end
    // Hang guard; the whole run is under a hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
endmodule
bind srs_status_set srs_status_set_assertions srs_status_set_assertions_inst(.clk(clk),
    .reset(reset), .ordCond(ordCond), .stdCond(stdCond), .clearStatus(clearStatus),
    .accValid(accValid), .accWrite(accWrite), .accSet(accSet), .accReg(accReg),
    .accWData(accWData), .accRData(accRData), .accRValid(accRValid),
    .ordSummary(ordSummary), .stdSummary(stdSummary));
`default_nettype wire
